/* File: inc/dvr_pkg.sv */
// Shared constants for the pixel output port of the video link receiver.
// Assumes a 32-bit AHB-Lite register bus and a separate link clock.

package dvr_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [31:0] DVR_CTRL_OFFS = 32'h0000_0000;
    localparam logic [31:0] DVR_STAT_OFFS = 32'h0000_0004;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int DVR_CTRL_W = 6;
    localparam int DVR_FMT_BIT = 0;   // Gated clock for DSTN panels
    localparam int DVR_POL_BIT = 1;   // Latch on rising edge when high
    localparam int DVR_PIX_BIT = 2;   // Two pixels per clock when high
    localparam int DVR_STAGGER_SELECT_N_BIT = 3;  // Stagger odd bus when low
    localparam int DVR_PD_BIT = 4;    // Whole port powered down when low
    localparam int DVR_PDO_BIT = 5;   // Drivers powered down when low
    localparam logic [5:0] DVR_CTRL_RST = 6'h38;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int DVR_STAT_LA_BIT = 0; // Link active indicator

    // ----------------------------------------------------------------
    // Timing counts in link clock cycles
    // ----------------------------------------------------------------
    localparam logic [1:0] DVR_HALF_ONE = 2'h1; // Half period, one pixel
    localparam logic [1:0] DVR_HALF_TWO = 2'h2; // Half period, two pixels
    localparam int DVR_IDLE_DEF = 1048576;      // No enable edge: inactive
    localparam int DVR_IDLE_W = 21;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [23:0] dvr_px_t;

endpackage : dvr_pkg

/* File: inc/dvr_word_if.sv */
// Carrier for packed output words between the packer and output stage.
// Assumes both ends run on the link clock.
`timescale 1ns/1ps

interface dvr_word_if;
    logic stb;                  // One-cycle pulse: new output word
    dvr_pkg::dvr_px_t even_px;  // Even pixel, blue in low byte
    dvr_pkg::dvr_px_t odd_px;   // Odd pixel, zero in one-pixel mode
    logic de;                   // Active video enable for the word
    logic hs;                   // Line sync
    logic vs;                   // Frame sync
    logic [2:0] ctl;            // General control bits
    modport src (output stb, even_px, odd_px, de, hs, vs, ctl);
    modport dst (input stb, even_px, odd_px, de, hs, vs, ctl);
endinterface : dvr_word_if

/* File: rtl/dvr_packer.sv */
// Packs the upstream pixel stream into one- or two-pixel output words.
// Assumes a pixel strobe at most every second link clock cycle.
`timescale 1ns/1ps

module dvr_packer (
    // Link clock, reset and enable
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic link_ce,
    // Mode
    input wire logic two_px,
    // Upstream pixel stream
    input wire logic px_stb,
    input wire logic [7:0] px_red,
    input wire logic [7:0] px_green,
    input wire logic [7:0] px_blue,
    input wire logic px_de,
    input wire logic px_hs,
    input wire logic px_vs,
    input wire logic [2:0] px_ctl,
    // Packed words
    dvr_word_if.src word
);
    import dvr_pkg::*;

    // Colour layout on a bus: blue low, green middle, red high
    function automatic dvr_px_t pack_rgb(input logic [7:0] r,
                                         input logic [7:0] g,
                                         input logic [7:0] b);
        pack_rgb = {r, g, b};
    endfunction : pack_rgb

    logic slot_r;       // Parity of the pixel within the line
    logic de_last_r;    // Enable of the previous strobe
    dvr_px_t hold_r;    // Even pixel waiting for its partner
    logic eff_slot;     // Parity after a line start restarts it
    dvr_px_t cur_px;

    // A line starts (or blanking starts) whenever the enable changes
    assign eff_slot = (px_de != de_last_r) ? 1'b0 : slot_r;
    assign cur_px = pack_rgb(px_red, px_green, px_blue);

    // ----------------------------------------------------------------
    // Packing
    // ----------------------------------------------------------------
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            slot_r <= 1'b0;
            de_last_r <= 1'b0;
            hold_r <= '0;
            word.stb <= 1'b0;
            word.even_px <= '0;
            word.odd_px <= '0;
            word.de <= 1'b0;
            word.hs <= 1'b0;
            word.vs <= 1'b0;
            word.ctl <= '0;
        end
        else if (link_ce)
        begin
            word.stb <= 1'b0;
            if (px_stb)
            begin
                de_last_r <= px_de;
                slot_r <= ~eff_slot; // Pixel zero is even
                // One word per strobe, or per pair in two-pixel mode
                if (!two_px || eff_slot)
                begin
                    word.stb <= 1'b1;
                    word.de <= px_de;
                    word.hs <= px_hs;
                    word.vs <= px_vs;
                    word.ctl <= px_ctl;
                end
                if (!two_px)
                begin
                    // All pixels on the even bus, odd bus low
                    word.even_px <= px_de ? cur_px : '0;
                    word.odd_px <= '0;
                end
                else if (!eff_slot)
                    hold_r <= px_de ? cur_px : '0;
                else
                begin
                    // Even and odd of one pair in the same word
                    word.even_px <= hold_r;
                    word.odd_px <= px_de ? cur_px : '0;
                end
            end
        end
    end

    a_one_px_map: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && px_stb && px_de && !two_px |=> word.stb
        && word.even_px == {$past(px_red), $past(px_green), $past(px_blue)}
        && word.odd_px == '0)
        else $error("one pixel word mismatch");

    a_pair_map: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && px_stb && px_de && two_px && eff_slot
        |=> word.stb && word.even_px == $past(hold_r)
        && word.odd_px[7:0] == $past(px_blue))
        else $error("pair word mismatch");

    a_line_even: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && px_stb && px_de && !de_last_r |=> slot_r)
        else $error("line start not even");

endmodule : dvr_packer

/* File: rtl/dvr_pixel_out.sv */
// Pixel output port of a video link receiver: AHB-Lite control plane on
// the core clock, pixel packing and panel outputs on the link clock.
// Assumes upstream decode logic on link_clk delivers a pixel stream.
//
// Function
// - Gated clock mode stops pixel clock outside video
// - All outputs launched from the pixel clock; indicator, enables, staggered odd bus are not
// - Polarity select picks the latching edge
// - Full power down floats every output
// - Driver power down spares indicator and ctl1
// - Two-pixel mode: pair on even, odd buses
// - One-pixel mode: all pixels on even bus
// - Pixel zero of every line is even
// - Even bus: blue low, green, red high
// - Odd blue in two-pixel mode, else low
// - Odd green, red likewise, else low
// - Enable high in video, low in blanking
// - Stagger select delays the odd bus
// - Indicator high while enable keeps toggling
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps

module dvr_pixel_out #(
    // Link cycles without an enable edge before the link is inactive
    parameter int IDLE_LIMIT = dvr_pkg::DVR_IDLE_DEF
) (
    // Core clock, reset and enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic core_ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link clock and upstream pixel stream
    input wire logic link_clk,
    input wire logic px_stb,
    input wire logic [7:0] px_red,
    input wire logic [7:0] px_green,
    input wire logic [7:0] px_blue,
    input wire logic px_de,
    input wire logic px_hs,
    input wire logic px_vs,
    input wire logic [2:0] px_ctl,
    // Panel outputs
    output logic output_pixel_clock,
    output dvr_pkg::dvr_px_t even_pixel_bus,
    output dvr_pkg::dvr_px_t odd_pixel_bus,
    output logic active_video_enable,
    output logic line_sync,
    output logic frame_sync,
    output logic [2:0] general_control_outputs,
    output logic link_active_indicator,
    // Output enables, low while driving
    output logic drv_oe_n,
    output logic keep_oe_n
);
    import dvr_pkg::*;

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    // Used both for fresh reads and for reads that follow a write
    function automatic logic [31:0] reg_read(input logic [31:0] a,
                                             input logic [5:0] c,
                                             input logic la);
        reg_read = 32'h0000_0000;
        if (a == DVR_CTRL_OFFS)
            reg_read = {26'h0, c};
        else if (a == DVR_STAT_OFFS)
            reg_read[DVR_STAT_LA_BIT] = la;
    endfunction : reg_read

    // ----------------------------------------------------------------
    // Core domain state
    // ----------------------------------------------------------------
    logic [5:0] ctrl_r;         // Mode and power control
    logic wr_pend_r;            // Write data phase due
    logic [31:0] wr_addr_r;     // Address of the pending write
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic la_meta_r;            // Indicator crossing, first stage
    logic la_sync_r;            // Indicator crossing, second stage
    logic [5:0] ctrl_now;       // Control with a pending write folded in
    logic ahb_go;               // Address phase accepted

    assign ahb_go = hready && hsel && htrans[1];

    // A read right after a write sees the written value
    assign ctrl_now = (wr_pend_r && wr_addr_r == DVR_CTRL_OFFS) ?
                      hwdata[5:0] : ctrl_r;

    // ----------------------------------------------------------------
    // Bus phases
    // ----------------------------------------------------------------
    // Zero wait states, so the data phase always ends in one cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            hrdata_r <= '0;
            hreadyout_r <= 1'b1;
        end
        else if (core_ce)
        begin
            hreadyout_r <= 1'b1;
            wr_pend_r <= ahb_go && hwrite;
            if (ahb_go)
            begin
                // Word aligned; low address bits do not matter
                wr_addr_r <= {haddr[31:2], 2'b00};
                if (!hwrite)
                    hrdata_r <= reg_read({haddr[31:2], 2'b00},
                                         ctrl_now, la_sync_r);
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Unmapped writes are dropped; the answer is still OKAY
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ctrl_r <= DVR_CTRL_RST;
        else if (core_ce && wr_pend_r && wr_addr_r == DVR_CTRL_OFFS)
            ctrl_r <= hwdata[5:0];
    end

    // ----------------------------------------------------------------
    // Indicator back into the core domain
    // ----------------------------------------------------------------
    // Synchroniser is not frozen by the enable so status stays live
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            la_meta_r <= 1'b0;
            la_sync_r <= 1'b0;
        end
        else
        begin
            la_meta_r <= link_active_indicator;
            la_sync_r <= la_meta_r;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;

    // ----------------------------------------------------------------
    // Crossing into the link domain
    // ----------------------------------------------------------------
    logic rst_meta_r;           // Reset crossing
    logic link_rst;
    logic ce_meta_r;            // Enable crossing
    logic link_ce;
    logic [5:0] cfg_meta_r;     // Control crossing
    logic [5:0] cfg_s;

    // Bits cross one by one; software should change one mode at a
    // time, since a multi-bit change may land over two link cycles
    always_ff @(posedge link_clk)
    begin
        rst_meta_r <= sys_rst;
        link_rst <= rst_meta_r;
        ce_meta_r <= core_ce;
        link_ce <= ce_meta_r;
        cfg_meta_r <= ctrl_r;
        cfg_s <= cfg_meta_r;
    end

    logic fmt_s, pol_s, two_px_s, stagger_select_n_n_s, pd_n_s, pdo_n_s;
    assign fmt_s = cfg_s[DVR_FMT_BIT];
    assign pol_s = cfg_s[DVR_POL_BIT];
    assign two_px_s = cfg_s[DVR_PIX_BIT];
    assign stagger_select_n_n_s = cfg_s[DVR_STAGGER_SELECT_N_BIT];
    assign pd_n_s = cfg_s[DVR_PD_BIT];
    assign pdo_n_s = cfg_s[DVR_PDO_BIT];

    // ----------------------------------------------------------------
    // Packer
    // ----------------------------------------------------------------
    dvr_word_if word ();

    // Inputs are ignored entirely while the port is powered down
    dvr_packer u_packer (
        .link_clk (link_clk),
        .link_rst (link_rst),
        .link_ce (link_ce && pd_n_s),
        .two_px (two_px_s),
        .px_stb (px_stb),
        .px_red (px_red),
        .px_green (px_green),
        .px_blue (px_blue),
        .px_de (px_de),
        .px_hs (px_hs),
        .px_vs (px_vs),
        .px_ctl (px_ctl),
        .word (word)
    );

    // ----------------------------------------------------------------
    // Output word stage
    // ----------------------------------------------------------------
    logic [1:0] cnt_r;          // Link cycles into the clock period
    logic [1:0] cnt_inc;        // Next count, wrapped at one period
    logic odd_pend_r;           // Staggered odd bus update due
    dvr_px_t odd_hold_r;        // Odd pixel waiting for its slot

    // Every output of this stage but a staggered odd bus changes only when a word loads, on the launch edge of the clock outside gated blanking
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            even_pixel_bus <= '0;
            odd_pixel_bus <= '0;
            active_video_enable <= 1'b0;
            line_sync <= 1'b0;
            frame_sync <= 1'b0;
            general_control_outputs <= '0;
            odd_pend_r <= 1'b0;
            odd_hold_r <= '0;
            cnt_r <= '0;
        end
        else if (link_ce)
        begin
            if (word.stb)
            begin
                cnt_r <= '0;
                even_pixel_bus <= word.even_px;
                active_video_enable <= word.de;
                line_sync <= word.hs;
                frame_sync <= word.vs;
                general_control_outputs <= word.ctl;
                // Staggering moves the odd bus a quarter period later
                if (two_px_s && !stagger_select_n_n_s)
                begin
                    odd_pend_r <= 1'b1;
                    odd_hold_r <= word.odd_px;
                end
                else
                begin
                    odd_pend_r <= 1'b0;
                    odd_pixel_bus <= word.odd_px;
                end
            end
            else
            begin
                // Period counter wraps so the clock runs with no words
                cnt_r <= cnt_inc;
                if (odd_pend_r)
                begin
                    odd_pixel_bus <= odd_hold_r;
                    odd_pend_r <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Output pixel clock
    // ----------------------------------------------------------------
    // The clock is a flop, so it is one link cycle behind nothing: the
    // same edge that loads a word moves the clock to its launch level, or low in gated blanking
    logic [1:0] half_cyc;
    logic de_now;
    logic output_pixel_clock_nxt;

    assign half_cyc = two_px_s ? DVR_HALF_TWO : DVR_HALF_ONE;
    // One pixel: period of 2 link cycles; two pixels: period of 4
    assign cnt_inc = (two_px_s || cnt_r == 2'h0) ? cnt_r + 2'h1 : 2'h0;
    assign de_now = word.stb ? word.de : active_video_enable;

    always_comb
    begin
        // Launch level is the opposite of the latching level
        if (word.stb)
            output_pixel_clock_nxt = ~pol_s;
        else if (cnt_inc >= half_cyc)
            output_pixel_clock_nxt = pol_s;
        else
            output_pixel_clock_nxt = ~pol_s;
        // Gated mode holds the clock low through blanking
        if (fmt_s && !de_now)
            output_pixel_clock_nxt = 1'b0;
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
            output_pixel_clock <= 1'b0;
        else if (link_ce)
            output_pixel_clock <= output_pixel_clock_nxt;
    end

    // ----------------------------------------------------------------
    // Link activity
    // ----------------------------------------------------------------
    logic [DVR_IDLE_W-1:0] idle_cnt_r;  // Cycles since an enable edge
    logic de_last_r;

    // Limitation: a blank longer than the limit drops the indicator
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            idle_cnt_r <= DVR_IDLE_W'(IDLE_LIMIT);
            de_last_r <= 1'b0;
            link_active_indicator <= 1'b0;
        end
        else if (link_ce)
        begin
            de_last_r <= active_video_enable;
            if (active_video_enable != de_last_r)
            begin
                idle_cnt_r <= '0;
                link_active_indicator <= 1'b1;
            end
            else if (idle_cnt_r < DVR_IDLE_W'(IDLE_LIMIT))
                idle_cnt_r <= idle_cnt_r + 1'b1;
            else
                link_active_indicator <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Output enables
    // ----------------------------------------------------------------
    // Indicator and ctl1 stay on so the indicator can wake the drivers
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            drv_oe_n <= 1'b1;
            keep_oe_n <= 1'b1;
        end
        else if (link_ce)
        begin
            drv_oe_n <= !(pd_n_s && pdo_n_s);
            keep_oe_n <= !pd_n_s;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_clk_gated: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && fmt_s && !word.stb && !active_video_enable
        |=> !output_pixel_clock)
        else $error("pixel clock runs in blanking");

    a_clk_free: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && !fmt_s && !two_px_s && !word.stb && cnt_r == 2'h0
        |=> output_pixel_clock == $past(pol_s))
        else $error("pixel clock stalled");

    a_launch_edge: assert property (@(posedge link_clk)
        disable iff (link_rst)
        link_ce && word.stb && !(fmt_s && !word.de)
        |=> output_pixel_clock == !$past(pol_s)
        && even_pixel_bus == $past(word.even_px))
        else $error("word not on launch edge");

    a_de_follow: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && word.stb |=> active_video_enable == $past(word.de))
        else $error("enable not launched");

    a_stagger_on: assert property (@(posedge link_clk)
        disable iff (link_rst)
        link_ce && word.stb && two_px_s && !stagger_select_n_n_s ##1 link_ce
        |=> odd_pixel_bus == $past(word.odd_px, 2))
        else $error("staggered odd bus late");

    a_stagger_off: assert property (@(posedge link_clk)
        disable iff (link_rst)
        link_ce && word.stb && !(two_px_s && !stagger_select_n_n_s)
        |=> odd_pixel_bus == $past(word.odd_px))
        else $error("odd bus not simultaneous");

    a_full_pd: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && !pd_n_s |=> drv_oe_n && keep_oe_n)
        else $error("driving while powered down");

    a_drv_pd: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ce && pd_n_s && !pdo_n_s |=> drv_oe_n && !keep_oe_n)
        else $error("driver power down wrong");

    a_link_wake: assert property (@(posedge link_clk)
        disable iff (link_rst)
        link_ce && active_video_enable != de_last_r
        |=> link_active_indicator && idle_cnt_r == '0)
        else $error("indicator not raised");

endmodule : dvr_pixel_out

/* File: tb/dvr_panel_sink.sv */
// Panel-side model: holds what a panel latches from the port.
// Assumes polarity select high, so the rising clock edge latches.
`timescale 1ns/1ps

module dvr_panel_sink (
    // Panel inputs
    input wire logic pclk,
    input wire logic [23:0] even_in,
    input wire logic [23:0] odd_in,
    input wire logic de_in,
    // Latched values
    output logic [23:0] even_cap,
    output logic [23:0] odd_cap,
    output logic de_cap
);
    // Latch on the rising edge only; data launched late shows up here
    always_ff @(posedge pclk)
    begin
        even_cap <= even_in;
        odd_cap <= odd_in;
        de_cap <= de_in;
    end
endmodule : dvr_panel_sink

/* File: tb/dvr_pixel_out_test.sv */
// Bench for the pixel output port: bus tasks, pixel stream, checks.
// Assumes a zero-wait AHB-Lite slave and a free 12 ns link clock.
`timescale 1ns/1ps

module dvr_pixel_out_test;
    import dvr_pkg::*;
    logic core_clk = 0, sys_rst = 1, link_clk = 0, px_stb = 0, px_de = 0;
    logic hsel = 0, hwrite = 0, seen;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, opc, ave, ls, fs, la, drv_oe_n, keep_oe_n, dcap;
    logic [23:0] px = 24'h0, evb, odb, ecap, ocap;
    logic [2:0] gco;
    int mismatches = 0, comparisons = 0;
    // Unrelated clocks: 50 ns core, 12 ns link
    always #25 core_clk = ~core_clk;
    always #6 link_clk = ~link_clk;
    dvr_pixel_out #(.IDLE_LIMIT(64)) i_dvr_pixel_out (
        .core_clk(core_clk), .sys_rst(sys_rst), .core_ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link_clk(link_clk), .px_stb(px_stb), .px_red(px[23:16]),
        .px_green(px[15:8]), .px_blue(px[7:0]), .px_de(px_de),
        .px_hs(~px_de), .px_vs(1'b0), .px_ctl(px[2:0]),
        .output_pixel_clock(opc), .even_pixel_bus(evb),
        .odd_pixel_bus(odb), .active_video_enable(ave), .line_sync(ls),
        .frame_sync(fs), .general_control_outputs(gco),
        .link_active_indicator(la), .drv_oe_n(drv_oe_n),
        .keep_oe_n(keep_oe_n));
    dvr_panel_sink i_dvr_panel_sink (.pclk(opc), .even_in(evb),
        .odd_in(odb), .de_in(ave), .even_cap(ecap), .odd_cap(ocap),
        .de_cap(dcap));
    // Verdict and end of run
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] got,
        input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Bounded wait for hready; a hang ends the run
    task wrdy;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (hreadyout === 1'b1)
                return;
        end
        mismatches++;
        results();
    endtask : wrdy
    // One single word transfer; read data lands in rd
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wrdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wrdy();
        rd = hrdata;
    endtask : xfer
    // One upstream pixel, strobe every second link cycle
    task pix(input logic de, input logic [23:0] v);
        @(posedge link_clk);
        px_stb <= 1'b1;
        px_de <= de;
        px <= v;
        @(posedge link_clk);
        px_stb <= 1'b0;
    endtask : pix
    task lk(input int n);
        repeat (n) @(posedge link_clk);
    endtask : lk
    // Has the output clock been high at all over 24 link cycles
    task ck(input logic exp);
        seen = 1'b0;
        repeat (24) @(negedge link_clk) seen = seen | opc;
        chk("pixel clock", seen, exp);
    endtask : ck
    initial
    begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        lk(4);
        xfer(0, DVR_CTRL_OFFS, 0);
        chk("ctrl reset", rd, {26'h0, DVR_CTRL_RST});
        xfer(0, 32'h10, 0);
        chk("unmapped", rd, 0);
        ck(1'b1);
        xfer(1, DVR_CTRL_OFFS, 32'h3a);
        lk(4);
        pix(1, 24'h112233);
        pix(1, 24'h445566);
        lk(6);
        chk("even one", ecap, 24'h445566);
        chk("odd one", ocap, 0);
        chk("enable", dcap, 1);
        pix(0, 0);
        pix(0, 0);
        lk(6);
        chk("blank", ave, 0);
        chk("line sync", ls, 1);
        xfer(1, DVR_CTRL_OFFS, 32'h3e);
        lk(4);
        pix(1, 24'ha1b2c3);
        pix(1, 24'hd4e5f6);
        lk(8);
        chk("even two", ecap, 24'ha1b2c3);
        chk("odd two", ocap, 24'hd4e5f6);
        pix(0, 0);
        pix(0, 0);
        lk(6);
        xfer(0, DVR_STAT_OFFS, 0);
        chk("link up", rd[0], 1);
        lk(100);
        xfer(0, DVR_STAT_OFFS, 0);
        chk("link idle", rd[0], 0);
        xfer(1, DVR_CTRL_OFFS, 32'h3b);
        lk(4);
        ck(1'b0);
        xfer(1, DVR_CTRL_OFFS, 32'h1a);
        lk(6);
        chk("drv oe", drv_oe_n, 1);
        chk("keep oe", keep_oe_n, 0);
        xfer(1, DVR_CTRL_OFFS, 32'h2a);
        lk(6);
        chk("pd drv", drv_oe_n, 1);
        chk("pd keep", keep_oe_n, 1);
        xfer(1, DVR_CTRL_OFFS, 32'h3a);
        lk(6);
        chk("on drv", drv_oe_n, 0);
        results();
    end
endmodule : dvr_pixel_out_test
